// [dv/decimation_datapath_control_checker.sv]
// Checker for the decimation control block: decoded settings and output flow.
// Assumes it is bound to the block top and sees only its ports.
`include "decim_ctrl_regs.vh"
module decimation_datapath_control_checker #(parameter DW = 16) (
  input wire clk,
  input wire rst,
  input wire [13:0] avsAddress,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  input wire [3:0] avsByteenable,
  input wire avsWaitrequest,
  input wire outValid,
  input wire outReady,
  input wire [DW-1:0] outSample,
  input wire dpEnable,
  input wire burstMode,
  input wire mixerActive,
  input wire [5:0] combFactor,
  input wire [5:0] secondaryFactor
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write accepted on lane 0; decoded outputs may lag it by two edges
  wire wrDone = avsWrite && !avsWaitrequest && avsByteenable[0];
  wire [11:0] idx = avsAddress[13:2];
  wire [7:0] wd = avsWritedata[7:0];
  chk_enable_follows: assert property (
    wrDone && idx == `IDX_DATAPATH_CONTROL |-> ##2 dpEnable == $past(wd[0], 2))
    else $error("enable does not follow write");
  chk_burst_follows: assert property (
    wrDone && idx == `IDX_DATAPATH_CONTROL |-> ##2 burstMode == $past(wd[2], 2))
    else $error("burst select does not follow write");
  chk_bypass_nonburst: assert property (
    wrDone && idx == `IDX_DATAPATH_CONTROL && !wd[2] |-> ##2 mixerActive == !$past(wd[1], 2))
    else $error("mixer bypass wrong in non-burst mode");
  chk_burst_mixer: assert property (burstMode |-> mixerActive)
    else $error("bypass acted in burst mode");
  chk_comb_rate: assert property (
    wrDone && idx == `IDX_COMB_CTRL && wd[1:0] != 2'h3
    |-> ##2 combFactor == (6'h04 << $past(wd[1:0], 2)))
    else $error("comb rate decode wrong");
  chk_sec_low: assert property (
    wrDone && idx == `IDX_SEC_DEC && wd[3:0] inside {4'h1, 4'h2, 4'h3}
    |-> ##2 secondaryFactor == (6'h02 << $past(wd[1:0], 2)))
    else $error("secondary code decode wrong");
  chk_sec_sixty: assert property (
    wrDone && idx == `IDX_SEC_DEC && wd[3:0] == 4'hF |-> ##2 secondaryFactor == 6'h3C)
    else $error("secondary code 1111 not by 60");
  chk_disabled_quiet: assert property (!dpEnable [*2] |-> !outValid)
    else $error("sample offered while disabled");
  chk_stall_holds: assert property (
    outValid && !outReady && dpEnable ##1 dpEnable |-> outValid && $stable(outSample))
    else $error("stalled sample changed or lost");
endmodule
bind decimation_datapath_control decimation_datapath_control_checker #(.DW(DW)) i_chk (
  .clk, .rst, .avsAddress, .avsWrite, .avsWritedata, .avsByteenable, .avsWaitrequest,
  .outValid, .outReady, .outSample, .dpEnable, .burstMode, .mixerActive, .combFactor,
  .secondaryFactor);

// [dv/decimation_datapath_control_tb_top.sv]
// Self-checking bench: register access, decoded settings and sample flow.
// Assumes default widths and the framer model on the output side.
`include "decim_ctrl_regs.vh"
module decimation_datapath_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, avsRead = 0, avsWrite = 0, inValid = 0, stall = 0;
  logic [13:0] avsAddress = 14'h0000;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
  logic [3:0] avsByteenable = 4'hF, inChannel = 4'h0, outChannel, lastChannel;
  logic [15:0] inSample = 16'h0, mixSample = 16'h0100, outSample, lastSample;
  logic [1:0] avsResponse;
  logic avsWaitrequest, outValid, outReady, dpEnable, burstMode, mixerActive, configError;
  logic [5:0] combFactor, secondaryFactor;
  int nErrors = 0, samplesChecked = 0, taken;
  decimation_datapath_control i_decimation_datapath_control (.clk, .rst, .avsAddress,
    .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
    .avsResponse, .inValid, .inChannel, .inSample, .mixSample, .outValid, .outReady,
    .outChannel, .outSample, .dpEnable, .burstMode, .mixerActive, .combFactor,
    .secondaryFactor, .configError);
  output_framer_model i_output_framer_model (.clk, .rst, .stall, .outValid, .outChannel,
    .outSample, .outReady, .lastChannel, .lastSample, .taken);
  initial begin
    forever #5 clk = ~clk;
  end
  task results;
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low, bounded
  task bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    avsAddress <= {idx, 2'b00};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      k++;
    end while (avsWaitrequest !== 1'b0 && k < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (k == 50) begin
      nErrors++;
      results();
    end
  endtask
  task sample(input logic [3:0] ch, input logic [15:0] v);
    @(posedge clk);
    inValid <= 1'b1;
    inChannel <= ch;
    inSample <= v;
    @(posedge clk);
    inValid <= 1'b0;
  endtask
  task waitTaken(input int n);
    int k;
    k = 0;
    while (taken < n && k < 50) begin
      @(posedge clk);
      k++;
    end
    check(taken, n);
    if (taken < n) results();
  endtask
  task testReset;
    logic [7:0] expv [5];
    expv = '{8'h04, 8'h00, 8'h10, 8'h08, 8'h00};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 12'h116 + i[11:0], 8'h00);
      check(rd, {24'h000000, expv[i]});
    end
    bus(1'b0, 12'h120, 8'h00);
    check(rd, 32'h0);
    check(avsResponse, 2'h0);
    bus(1'b0, `IDX_STATUS, 8'h00);
    check(rd, 32'h44);
    check(dpEnable, 1'b0);
    check(burstMode, 1'b1);
    $display("reset values done");
  endtask
  task testDecode;
    logic [3:0] codes [10];
    logic [5:0] facs [10];
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hF};
    facs = '{6'h01, 6'h04, 6'h08, 6'h10, 6'h0C, 6'h18, 6'h0A, 6'h14, 6'h28, 6'h3C};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `IDX_COMB_CTRL, i[7:0]);
      repeat (2) @(posedge clk);
      check(combFactor, 6'h04 << i);
    end
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, `IDX_SEC_DEC, {4'h0, codes[i]});
      repeat (2) @(posedge clk);
      check(secondaryFactor, facs[i]);
    end
    bus(1'b1, `IDX_SEC_DEC, 8'h04);
    repeat (2) @(posedge clk);
    check({configError, secondaryFactor}, 7'h40);
    bus(1'b1, `IDX_COMB_CTRL, 8'h04);
    bus(1'b0, `IDX_COMB_CTRL, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, `IDX_DATAPATH_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    check({burstMode, mixerActive}, 2'h0);
    bus(1'b1, `IDX_DATAPATH_CONTROL, 8'h06);
    repeat (2) @(posedge clk);
    check({burstMode, mixerActive}, 2'h3);
    $display("decode done");
  endtask
  task testStream;
    bus(1'b1, `IDX_SEC_DEC, 8'h00);
    bus(1'b1, `IDX_DATAPATH_CONTROL, 8'h1B);
    stall <= 1'b1;
    sample(4'h5, 16'h0123);
    sample(4'h9, 16'h0456);
    repeat (4) @(posedge clk);
    check({outValid, taken[3:0]}, 5'h10);
    stall <= 1'b0;
    waitTaken(2);
    check({lastChannel, lastSample}, 20'h90456);
    bus(1'b1, `IDX_SEC_DEC, 8'h01);
    repeat (3) sample(4'h2, 16'h0010);
    repeat (4) @(posedge clk);
    check(taken, 2);
    sample(4'h2, 16'h0010);
    waitTaken(3);
    check(lastChannel, 4'h2);
    bus(1'b1, `IDX_SEC_DEC, 8'h00);
    bus(1'b1, `IDX_DATAPATH_CONTROL, 8'h19);
    sample(4'h6, 16'h0000);
    waitTaken(4);
    check({lastChannel, lastSample}, 20'h60200);
    $display("stream done");
  endtask
  task testDisable;
    bus(1'b1, `IDX_SEC_DEC, 8'h00);
    stall <= 1'b1;
    sample(4'h3, 16'h0333);
    bus(1'b1, `IDX_DATAPATH_CONTROL, 8'h1A);
    sample(4'h1, 16'h0777);
    repeat (4) @(posedge clk);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    check({outValid, dpEnable}, 2'h0);
    check(taken, 4);
    $display("disable done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testDecode();
    testStream();
    testDisable();
    results();
  end
endmodule

// [dv/output_framer_model.sv]
// Output framer model: takes decimated samples over valid/ready.
// Assumes the bench raises stall to hold ready low as back-pressure.
module output_framer_model #(parameter DW = 16) (
  input wire clk,
  input wire rst,
  input wire stall,
  input wire outValid,
  input wire [3:0] outChannel,
  input wire [DW-1:0] outSample,
  output wire outReady,
  output logic [3:0] lastChannel,
  output logic [DW-1:0] lastSample,
  output int taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready drops only while a stall is asked for
  assign outReady = !stall;
  // Record each accepted sample; count lets the bench spot lost words
  always @(posedge clk) begin
    if (rst) begin
      taken <= 0;
    end else if (outValid && outReady) begin
      taken <= taken + 1;
      lastChannel <= outChannel;
      lastSample <= outSample;
    end
  end
endmodule

// [inc/decim_ctrl_regs.vh]
// Register map and field constants for the decimation datapath control block.
// Assumes an Avalon-MM slave with 32-bit data and word byte addresses = index * 4.
// Operation
// - Gain boost adds 6 dB only while the oscillator and mixer are in the path.
// - Burst select, reset one, picks averaging path; clear picks secondary decimator.
// - Mixer bypass skips oscillator and mixer in non-burst mode; ignored in burst mode.
// - Datapath enable, reset zero, switches all sixteen channel datapaths together.
// - Writing one to accumulator clear empties all comb accumulators; zero does nothing.
// - Two-bit comb rate, reset zero: 00 by 4, 01 by 8, 10 by 16.
// - Burst divisor, reset 0x10; software writes 1,12,14,16,18,24,28,32 or 36.
// - Burst average count, reset 0x8; software writes 8 or 16, never zero.
// - Secondary code: 0000 bypass, 0001-0011 by 4/8/16, 0110 by 12; not 0100/0101.
// - Source select feeds secondary decimator raw modulator data when set, comb output else.
// - Codes 0111 by 24, 1001 by 10 comb only, 1010 by 20, 1011 by 40, 1111 by 60.
`ifndef DECIM_CTRL_REGS_VH
`define DECIM_CTRL_REGS_VH
`define IDX_DATAPATH_CONTROL 12'h116
`define IDX_COMB_CTRL 12'h117
`define IDX_BURST_DIV 12'h118
`define IDX_BURST_AVG 12'h119
`define IDX_SEC_DEC 12'h11A
`define IDX_STATUS 12'h11B
`define BIT_DP_EN 0
`define BIT_MIX_BYP 1
`define BIT_BURST 2
`define BIT_GAIN 3
`define BIT_SRC_SEL 4
`define BIT_ACC_CLR 2
`define RST_DATAPATH_CONTROL 8'h04
`define RST_COMB_CTRL 8'h00
`define RST_BURST_DIV 8'h10
`define RST_BURST_AVG 8'h08
`define RST_SEC_DEC 8'h00
`define MASK_DATAPATH_CONTROL 8'h1F
`define MASK_COMB_CTRL 8'h03
`define MASK_SEC_DEC 8'h0F
`define GAIN_SHIFT 1
`endif

// [rtl/decimation_datapath_control.v]
// Control registers and a shared decimation stage for the sixteen-channel datapath.
// Assumes modulator samples arrive on clk with a valid strobe and a channel tag,
// and the output framer takes samples through valid/ready.
`include "decim_ctrl_regs.vh"
module decimation_datapath_control #(
  parameter DW = 16,
  parameter CHANNELS = 16
) (
  input wire clk,
  input wire rst,
  input wire [13:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  input wire [3:0] avsByteenable,
  output reg [31:0] avsReaddata,
  output wire avsWaitrequest,
  output reg [1:0] avsResponse,
  input wire inValid,
  input wire [3:0] inChannel,
  input wire signed [DW-1:0] inSample,
  input wire signed [DW-1:0] mixSample,
  output wire outValid,
  input wire outReady,
  output wire [3:0] outChannel,
  output wire [DW-1:0] outSample,
  output reg dpEnable,
  output reg burstMode,
  output reg mixerActive,
  output reg [5:0] combFactor,
  output reg [5:0] secondaryFactor,
  output reg configError
);
  localparam ACCW = DW + 8;
  // Group counter width; must hold the longest group length
  localparam PHASEW = 10;
  reg [7:0] dpCtrl;
  reg [7:0] combCtrl;
  reg [7:0] burstDivisor;
  reg [7:0] burstAverageCount;
  reg [7:0] secDec;
  reg accClearPulse;
  wire ackPending;
  wire busReq = avsRead || avsWrite;
  wire [11:0] regIdx = avsAddress[13:2];
  // Writes land on the answer edge, where the master sees waitrequest low;
  // taking them earlier would act on a transfer the bus has not yet accepted
  wire wrLow = avsWrite && avsByteenable[0] && ackPending;
  wire dataEn = dpCtrl[`BIT_DP_EN];
  wire isBurst = dpCtrl[`BIT_BURST];
  wire mixBypass = dpCtrl[`BIT_MIX_BYP];
  wire gainBoost = dpCtrl[`BIT_GAIN];
  wire srcRaw = dpCtrl[`BIT_SRC_SEL];
  wire [1:0] combRate = combCtrl[1:0];
  wire [3:0] secCode = secDec[3:0];

  // Comb rate code to factor
  function [5:0] combDecode;
    input [1:0] code;
    begin
      case (code)
        2'h0: combDecode = 6'h04;
        2'h1: combDecode = 6'h08;
        2'h2: combDecode = 6'h10;
        default: combDecode = 6'h00;
      endcase
    end
  endfunction

  // Secondary code to factor; zero marks an invalid code
  function [5:0] secDecode;
    input [3:0] code;
    begin
      case (code)
        4'h0: secDecode = 6'h01;
        4'h1: secDecode = 6'h04;
        4'h2: secDecode = 6'h08;
        4'h3: secDecode = 6'h10;
        4'h6: secDecode = 6'h0C;
        4'h7: secDecode = 6'h18;
        4'h9: secDecode = 6'h0A;
        4'hA: secDecode = 6'h14;
        4'hB: secDecode = 6'h28;
        4'hF: secDecode = 6'h3C;
        default: secDecode = 6'h00;
      endcase
    end
  endfunction

  // Burst result is the sum over H; a zero divisor passes the sum unchanged
  // rather than dividing by zero
  function [DW-1:0] burstScale;
    input [DW-1:0] sum;
    input [7:0] divisor;
    begin
      if (divisor == 8'h00) begin
        burstScale = sum;
      end else begin
        burstScale = sum / divisor;
      end
    end
  endfunction

  // Bus handshake states, one-hot
  localparam BUS_IDLE = 2'h1;
  localparam BUS_ACK = 2'h2;
  reg [1:0] busState;
  reg [1:0] next_busState;

  // One wait cycle per request; returning to idle after each answer
  // keeps a request still held on that edge from being answered twice
  always @* begin
    next_busState = busState;
    case (busState)
      BUS_IDLE: begin
        if (busReq) begin
          next_busState = BUS_ACK;
        end
      end
      BUS_ACK: begin
        next_busState = BUS_IDLE;
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge clk) begin
    if (rst) begin
      busState <= BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // Waitrequest is high only while a request waits for its answer cycle
  assign ackPending = (busState == BUS_ACK);
  assign avsWaitrequest = busReq && !ackPending;

  // Register writes, low byte lane only; reserved bits masked
  // Only lane 0 carries a register, so a write without it changes nothing
  always @(posedge clk) begin
    if (rst) begin
      dpCtrl <= `RST_DATAPATH_CONTROL;
      combCtrl <= `RST_COMB_CTRL;
      burstDivisor <= `RST_BURST_DIV;
      burstAverageCount <= `RST_BURST_AVG;
      secDec <= `RST_SEC_DEC;
      accClearPulse <= 1'b0;
    end else begin
      accClearPulse <= 1'b0;
      if (wrLow) begin
        case (regIdx)
          `IDX_DATAPATH_CONTROL: dpCtrl <= avsWritedata[7:0] & `MASK_DATAPATH_CONTROL;
          `IDX_COMB_CTRL: begin
            combCtrl <= avsWritedata[7:0] & `MASK_COMB_CTRL;
            accClearPulse <= avsWritedata[`BIT_ACC_CLR];
          end
          `IDX_BURST_DIV: burstDivisor <= avsWritedata[7:0];
          `IDX_BURST_AVG: burstAverageCount <= avsWritedata[7:0];
          `IDX_SEC_DEC: secDec <= avsWritedata[7:0] & `MASK_SEC_DEC;
          default: begin
          end
        endcase
      end
    end
  end

  // Read mux; unmapped words read zero with OKAY
  // Data loads on the taking edge and stands through the answer edge
  always @(posedge clk) begin
    if (rst) begin
      avsReaddata <= 32'h0;
      avsResponse <= 2'h0;
    end else if (avsRead && !ackPending) begin
      avsResponse <= 2'h0;
      case (regIdx)
        `IDX_DATAPATH_CONTROL: avsReaddata <= {24'h0, dpCtrl};
        `IDX_COMB_CTRL: avsReaddata <= {24'h0, combCtrl};
        `IDX_BURST_DIV: avsReaddata <= {24'h0, burstDivisor};
        `IDX_BURST_AVG: avsReaddata <= {24'h0, burstAverageCount};
        `IDX_SEC_DEC: avsReaddata <= {24'h0, secDec};
        `IDX_STATUS: avsReaddata <= {24'h0, configError, mixerActive, combFactor};
        default: avsReaddata <= 32'h0;
      endcase
    end
  end

  // Decoded outputs restart from the decode of the register reset values
  wire [7:0] dpReset = `RST_DATAPATH_CONTROL;
  wire [7:0] combReset = `RST_COMB_CTRL;
  wire [7:0] secReset = `RST_SEC_DEC;

  // codes the decoder leaves unmapped, and code 1001 on raw data
  wire secInvalid = (secDecode(secCode) == 6'h00) || (srcRaw && secCode == 4'h9);
  // Reserved comb rate and zero G or H would stall or divide by zero
  wire combInvalid = (combRate == 2'h3);
  wire burstInvalid = (burstAverageCount == 8'h00) || (burstDivisor == 8'h00);

  // Decoded configuration outputs and error flag
  always @(posedge clk) begin
    if (rst) begin
      dpEnable <= dpReset[`BIT_DP_EN];
      burstMode <= dpReset[`BIT_BURST];
      mixerActive <= dpReset[`BIT_BURST] || !dpReset[`BIT_MIX_BYP];
      combFactor <= combDecode(combReset[1:0]);
      secondaryFactor <= secDecode(secReset[3:0]);
      configError <= 1'b0;
    end else begin
      dpEnable <= dataEn;
      burstMode <= isBurst;
      // bypass only counts outside burst mode
      mixerActive <= isBurst || !mixBypass;
      combFactor <= combDecode(combRate);
      secondaryFactor <= secDecode(secCode);
      // any invalid setting raises the flag
      configError <= secInvalid || combInvalid || burstInvalid;
    end
  end

  // Per-channel accumulators and phase counters
  reg signed [ACCW-1:0] acc [0:CHANNELS-1];
  reg [PHASEW-1:0] phase [0:CHANNELS-1];
  reg [DW-1:0] stageData;
  reg [3:0] stageChan;
  reg stageValid;
  wire bufReady;
  wire signed [DW-1:0] pathIn;
  wire signed [DW:0] boosted;
  wire [PHASEW-1:0] ratio;
  wire [PHASEW-1:0] phaseNext;
  wire lastPhase;
  wire signed [ACCW-1:0] sumNow;
  integer k;

  // mixer choice and gain boost while the mixer is in use
  assign pathIn = mixerActive ? mixSample : inSample;
  assign boosted = (mixerActive && gainBoost) ? ({pathIn[DW-1], pathIn} <<< `GAIN_SHIFT)
                                              : {pathIn[DW-1], pathIn};
  // factor: average count in burst, else comb or raw then secondary
  // Longest group is comb 16 times secondary 60, hence the ten-bit count
  assign ratio = isBurst ? {2'h0, burstAverageCount}
               : (srcRaw ? {4'h0, secondaryFactor}
               : ({4'h0, combFactor} * {4'h0, secondaryFactor}));
  assign phaseNext = phase[inChannel] + {{(PHASEW-1){1'b0}}, 1'b1};
  // A zero factor from an invalid code makes every sample end a group
  assign lastPhase = (phaseNext >= ratio);
  assign sumNow = acc[inChannel] + {{(ACCW-DW-1){boosted[DW]}}, boosted};

  // Accumulate-and-dump; the sample stalls nothing upstream, so drop on full buffer
  // A long stall by the framer therefore loses input samples here
  always @(posedge clk) begin
    // clear pulse or disable idles all accumulators
    if (rst || accClearPulse || !dpEnable) begin
      for (k = 0; k < CHANNELS; k = k + 1) begin
        acc[k] <= {ACCW{1'b0}};
        phase[k] <= {PHASEW{1'b0}};
      end
      stageValid <= 1'b0;
      stageData <= {DW{1'b0}};
      stageChan <= 4'h0;
    end else begin
      if (stageValid && bufReady) begin
        stageValid <= 1'b0;
      end
      if (inValid && (!stageValid || bufReady)) begin
        if (lastPhase) begin
          acc[inChannel] <= {ACCW{1'b0}};
          phase[inChannel] <= {PHASEW{1'b0}};
          stageValid <= 1'b1;
          stageChan <= inChannel;
          // burst result is the sum over H; other modes pass the sum, so
          // the bypass code on raw data passes samples unchanged and long groups may wrap
          stageData <= isBurst ? burstScale(sumNow[DW-1:0], burstDivisor)
                               : sumNow[DW-1:0];
        end else begin
          acc[inChannel] <= sumNow;
          phase[inChannel] <= phaseNext;
        end
      end
    end
  end

  // buffer flushed while disabled, so from the second disabled cycle nothing valid reaches the framer
  skid_buffer #(.WIDTH(DW + 4)) outBuf (
    .clk(clk),
    .rst(rst),
    .flush(!dpEnable),
    .inValid(stageValid),
    .inReady(bufReady),
    .inData({stageChan, stageData}),
    .outValid(outValid),
    .outReady(outReady),
    .outData({outChannel, outSample})
  );
endmodule

// [rtl/skid_buffer.v]
// Two-entry valid/ready buffer in the sample path.
// Assumes source and sink on the same clock; reset synchronous.
module skid_buffer #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:1];
  reg [1:0] count;
  reg rdPtr;
  reg wrPtr;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  // Ready only while room exists, so a stalled sink stops the source
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem[rdPtr];
  // Pointers and fill count; flush drops everything
  always @(posedge clk) begin
    if (rst || flush) begin
      count <= 2'h0;
      rdPtr <= 1'b0;
      wrPtr <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (pop) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  // Storage has no reset; guarded by count
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule
